/* rtl/dtc_params.svh */
// Constants of the dual timer/counter pair: addresses, bit positions, phases and codes.
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH
`define DTC_ADDR_W 8
`define DTC_ADDR_CTL 8'h00
`define DTC_ADDR_MODE 8'h04
`define DTC_ADDR_TL0 8'h08
`define DTC_ADDR_TH0 8'h0C
`define DTC_ADDR_TL1 8'h10
`define DTC_ADDR_TH1 8'h14
`define DTC_ADDR_ACK 8'h18
`define DTC_TF1 7
`define DTC_TR1 6
`define DTC_TF0 5
`define DTC_TR0 4
`define DTC_IE1 3
`define DTC_IT1 2
`define DTC_IE0 1
`define DTC_IT0 0
`define DTC_GATE1 7
`define DTC_FUNC1 6
`define DTC_MODE1_LSB 4
`define DTC_GATE0 3
`define DTC_FUNC0 2
`define DTC_MODE0_LSB 0
`define DTC_FLAG_MASK 8'hAA
`define DTC_LAST_PHASE 3'h5
`define DTC_UPDATE_PHASE 3'h2
`define DTC_SAMPLE_PHASE 3'h4
`define DTC_PIN_IDLE 4'hF
`define DTC_IRQ_IDLE 2'h3
`define DTC_RESP_OKAY 2'h0
`define DTC_RESP_SLVERR 2'h2
`endif

/* rtl/dtc_pkg.sv */
// Types shared by the dual timer/counter pair.
package dtc_pkg;
    typedef enum logic [1:0] {DTC_MODE13, DTC_MODE16, DTC_MODE8R, DTC_MODESPLIT} dtc_mode_type;
    typedef enum logic [2:0] {DTC_SEL_CTL, DTC_SEL_MODE, DTC_SEL_TL0, DTC_SEL_TH0, DTC_SEL_TL1, DTC_SEL_TH1,
        DTC_SEL_ACK, DTC_SEL_NONE} dtc_sel_type;
    typedef struct packed {
        logic [7:0] tl;
        logic [7:0] th;
        logic ovf;
    } dtc_step_type;
    typedef struct packed {
        logic [7:0] ctl;
        logic [7:0] mode;
        logic [7:0] tl0;
        logic [7:0] th0;
        logic [7:0] tl1;
        logic [7:0] th1;
        logic [2:0] phase;
        logic [3:0] s1;
        logic [3:0] s2;
        logic [3:0] s3;
        logic [3:0] filt;
        logic [1:0] lastSmp;
        logic [1:0] pend;
        logic [1:0] irqPrev;
        logic awHave;
        logic wHave;
        logic [7:0] awAddr;
        logic [7:0] wData;
        logic wLane;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic baudTick;
    } dtc_state_type;
endpackage

/* rtl/dtc_timer_pair.sv */
// Dual timer/counter pair with an AXI4-Lite register slave.
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "dtc_params.svh"
module dtc_timer_pair
    import dtc_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire logic countPinZero,
    input wire logic countPinOne,
    input wire logic extIrqPinZero,
    input wire logic extIrqPinOne,
    output logic baudTick
);

    dtc_state_type st;
    dtc_state_type n;
    dtc_step_type r0;
    dtc_step_type r1;
    dtc_sel_type wSel;
    dtc_sel_type rSel;
    logic wrEn;
    logic upd;
    logic tick0;
    logic tick1;
    logic thTick;
    logic t0Split;
    logic [1:0] irqEdge;
    logic [7:0] setMask;
    logic [7:0] ctlBase;
    logic [7:0] rByte;

    // Maps a byte address onto a register select.
    function automatic dtc_sel_type dtcDecode(input logic [7:0] a);
        case (a)
            `DTC_ADDR_CTL: dtcDecode = DTC_SEL_CTL;
            `DTC_ADDR_MODE: dtcDecode = DTC_SEL_MODE;
            `DTC_ADDR_TL0: dtcDecode = DTC_SEL_TL0;
            `DTC_ADDR_TH0: dtcDecode = DTC_SEL_TH0;
            `DTC_ADDR_TL1: dtcDecode = DTC_SEL_TL1;
            `DTC_ADDR_TH1: dtcDecode = DTC_SEL_TH1;
            `DTC_ADDR_ACK: dtcDecode = DTC_SEL_ACK;
            default: dtcDecode = DTC_SEL_NONE;
        endcase
    endfunction

    // Advances one timer by one count in the given mode and reports rollover.
    function automatic dtc_step_type dtcStep(input logic [1:0] mode, input logic [7:0] tl,
        input logic [7:0] th, input logic inc);
        dtc_step_type r;
        r.tl = tl;
        r.th = th;
        r.ovf = 1'b0;
        if (inc) begin
            case (dtc_mode_type'(mode))
                DTC_MODE13: begin
                    {r.th, r.tl[4:0]} = {th, tl[4:0]} + 13'h0001;
                    r.ovf = &{th, tl[4:0]};
                end
                DTC_MODE16: begin
                    {r.th, r.tl} = {th, tl} + 16'h0001;
                    r.ovf = &{th, tl};
                end
                DTC_MODE8R: begin
                    if (&tl) begin
                        r.tl = th;
                        r.ovf = 1'b1;
                    end else begin
                        r.tl = tl + 8'h01;
                    end
                end
                default: begin
                    r.tl = tl + 8'h01;
                    r.ovf = &tl;
                end
            endcase
        end
        return r;
    endfunction

    // Next-state logic for the timers, the pin front end and the bus slave.
    always_comb begin
        n = st;
        wrEn = 1'b0;
        ctlBase = st.ctl;
        setMask = 8'h00;
        rByte = 8'h00;
        // Three-stage pin synchroniser; the filtered level follows once stages two and three agree.
        n.s1 = {extIrqPinOne, extIrqPinZero, countPinOne, countPinZero};
        n.s2 = st.s1;
        n.s3 = st.s2;
        n.filt = (st.s2 & st.s3) | (st.filt & (st.s2 ^ st.s3));
        // Six-clock machine cycle.
        n.phase = (st.phase == `DTC_LAST_PHASE) ? 3'h0 : 3'(st.phase + 3'h1);
        upd = (st.phase == `DTC_UPDATE_PHASE);
        // Count pins are sampled once per cycle; a high-then-low pair pends a count.
        if (st.phase == `DTC_SAMPLE_PHASE) begin
            n.lastSmp = st.filt[1:0];
            n.pend = st.pend | (st.lastSmp & ~st.filt[1:0]);
        end
        if (upd) begin
            n.pend = 2'b00;
        end
        t0Split = (st.mode[`DTC_MODE0_LSB +: 2] == DTC_MODESPLIT);
        // Enables combine run, gate and function select; counts are never cleared by run.
        tick0 = upd && st.ctl[`DTC_TR0] && (!st.mode[`DTC_GATE0] || st.filt[2])
            && (st.mode[`DTC_FUNC0] ? st.pend[0] : 1'b1);
        tick1 = upd && (t0Split || st.ctl[`DTC_TR1]) && (!st.mode[`DTC_GATE1] || st.filt[3])
            && (st.mode[`DTC_FUNC1] ? st.pend[1] : 1'b1)
            && (st.mode[`DTC_MODE1_LSB +: 2] != DTC_MODESPLIT);
        thTick = upd && t0Split && st.ctl[`DTC_TR1];
        r0 = dtcStep(st.mode[`DTC_MODE0_LSB +: 2], st.tl0, st.th0, tick0);
        r1 = dtcStep(st.mode[`DTC_MODE1_LSB +: 2], st.tl1, st.th1, tick1);
        n.tl0 = r0.tl;
        n.th0 = r0.th;
        n.tl1 = r1.tl;
        n.th1 = r1.th;
        setMask[`DTC_TF0] = r0.ovf;
        // In split mode the high byte of timer 0 owns the timer 1 flag.
        if (t0Split) begin
            n.th0 = thTick ? st.th0 + 8'h01 : st.th0;
            setMask[`DTC_TF1] = thTick && (&st.th0);
        end else begin
            setMask[`DTC_TF1] = r1.ovf;
        end
        n.baudTick = r1.ovf;
        // External interrupt flags: falling edge or low level as the type bit says.
        irqEdge = st.irqPrev & ~st.filt[3:2];
        n.irqPrev = st.filt[3:2];
        setMask[`DTC_IE0] = st.ctl[`DTC_IT0] ? irqEdge[0] : ~st.filt[2];
        setMask[`DTC_IE1] = st.ctl[`DTC_IT1] ? irqEdge[1] : ~st.filt[3];
        // Write address and data are taken independently.
        if (s_axi_awvalid && st.awready) begin
            n.awHave = 1'b1;
            n.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wready) begin
            n.wHave = 1'b1;
            n.wData = s_axi_wdata[7:0];
            n.wLane = s_axi_wstrb[0];
        end
        if (st.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        // Write commits once both halves are held; a bus write to a count byte wins over counting.
        wSel = dtcDecode(st.awAddr);
        if (st.awHave && st.wHave && !st.bvalid) begin
            wrEn = st.wLane;
            n.awHave = 1'b0;
            n.wHave = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = (wSel == DTC_SEL_NONE) ? `DTC_RESP_SLVERR : `DTC_RESP_OKAY;
            if (st.wLane) begin
                case (wSel)
                    DTC_SEL_CTL: ctlBase = st.wData;
                    DTC_SEL_MODE: n.mode = st.wData;
                    DTC_SEL_TL0: n.tl0 = st.wData;
                    DTC_SEL_TH0: n.th0 = st.wData;
                    DTC_SEL_TL1: n.tl1 = st.wData;
                    DTC_SEL_TH1: n.th1 = st.wData;
                    DTC_SEL_ACK: ctlBase = st.ctl & ~(st.wData & `DTC_FLAG_MASK);
                    default: ctlBase = st.ctl;
                endcase
            end
        end
        // A hardware set in the cycle of a clear keeps the flag.
        n.ctl = ctlBase | setMask;
        // Read path answers one cycle after the address is taken.
        rSel = dtcDecode(s_axi_araddr);
        case (rSel)
            DTC_SEL_CTL: rByte = st.ctl;
            DTC_SEL_MODE: rByte = st.mode;
            DTC_SEL_TL0: rByte = st.tl0;
            DTC_SEL_TH0: rByte = st.th0;
            DTC_SEL_TL1: rByte = st.tl1;
            DTC_SEL_TH1: rByte = st.th1;
            default: rByte = 8'h00;
        endcase
        if (s_axi_arvalid && st.arready) begin
            n.rvalid = 1'b1;
            n.rdata = {24'h000000, rByte};
            n.rresp = (rSel == DTC_SEL_NONE) ? `DTC_RESP_SLVERR : `DTC_RESP_OKAY;
        end else if (st.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        n.awready = !n.awHave && !n.bvalid;
        n.wready = !n.wHave && !n.bvalid;
        n.arready = !n.rvalid;
    end

    // State register; reset clears every register and count byte.
    // The pin chain resets to the idle high level of the pins, so no false level or edge follows reset.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '0;
            st.s1 <= `DTC_PIN_IDLE;
            st.s2 <= `DTC_PIN_IDLE;
            st.s3 <= `DTC_PIN_IDLE;
            st.filt <= `DTC_PIN_IDLE;
            st.irqPrev <= `DTC_IRQ_IDLE;
        end else begin
            st <= n;
        end
    end

    assign s_axi_awready = st.awready;
    assign s_axi_wready = st.wready;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;
    assign baudTick = st.baudTick;

    default clocking dtcCb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    // The machine cycle wraps after its sixth clock.
    a_machine_cycle: assert property (st.phase == `DTC_LAST_PHASE |=> st.phase == 3'h0 ##2 upd)
        else $error("machine cycle phase did not wrap");

    // Counter function does not count without a pended edge.
    a_counter_edge: assert property (st.mode[`DTC_FUNC0] && !st.pend[0] && upd && !wrEn
        |=> $stable(st.tl0))
        else $error("counter moved without a detected edge");

    // Count bytes other than TH0 change only at the update phase or on a bus write.
    a_update_phase: assert property (!upd && !wrEn |=> $stable({st.tl0, st.tl1, st.th1}))
        else $error("count changed outside the update phase");

    // Outside split mode a stopped timer 0 keeps its count.
    a_run_hold: assert property (!st.ctl[`DTC_TR0] && !t0Split && !wrEn |=> $stable({st.th0, st.tl0}))
        else $error("timer 0 counted while stopped");

    // Sixteen-bit timer increments by one each machine cycle.
    a_mode16_inc: assert property (upd && st.ctl[`DTC_TR0] && st.mode[3:0] == 4'h1 && !wrEn
        |=> {st.th0, st.tl0} == 16'($past({st.th0, st.tl0}) + 16'h0001))
        else $error("16-bit timer did not increment");

    // Sixteen-bit rollover sets the overflow flag.
    a_ovf_flag: assert property (tick0 && st.mode[1:0] == 2'h1 && {st.th0, st.tl0} == 16'hFFFF
        |=> st.ctl[`DTC_TF0] && st.tl0 == 8'h00)
        else $error("overflow flag not set on rollover");

    // Auto-reload copies the high byte into the low byte.
    a_reload_copy: assert property (tick0 && st.mode[1:0] == 2'h2 && st.tl0 == 8'hFF && !wrEn
        |=> st.tl0 == $past(st.th0) && $stable(st.th0) && st.ctl[`DTC_TF0])
        else $error("auto-reload failed");

    // Timer 1 in its split mode holds its count.
    a_t1_hold: assert property (st.mode[5:4] == 2'h3 && !wrEn |=> $stable({st.th1, st.tl1}))
        else $error("timer 1 counted in mode 3");

    // Split high byte counts on timer 1 run bit.
    a_split_high: assert property (upd && t0Split && st.ctl[`DTC_TR1] && !wrEn
        |=> st.th0 == 8'($past(st.th0) + 8'h01))
        else $error("split high byte did not count");

endmodule

/* testbench/dtc_pin_source.sv */
// Model of the count and interrupt pins that face the timer pair.
`timescale 1ns/1ps
module dtc_pin_source (
    input wire logic clk,
    output logic [1:0] countPins,
    output logic [1:0] irqPins
);
    // All pins rest high until a scenario moves them.
    initial begin
        countPins = 2'h3;
        irqPins = 2'h3;
    end
    // Falling edges, each level held two machine cycles so it is sampled.
    task automatic pulses(input int idx, input int n);
        repeat (n) begin
            @(posedge clk);
            countPins[idx] <= 1'h0;
            repeat (12) @(posedge clk);
            countPins[idx] <= 1'h1;
            repeat (12) @(posedge clk);
        end
    endtask
    // Sets an interrupt pin and holds it long enough to pass the synchroniser.
    task automatic setIrq(input int idx, input logic v);
        @(posedge clk);
        irqPins[idx] <= v;
        repeat (12) @(posedge clk);
    endtask
endmodule

/* testbench/tb_dtc_timer_pair.sv */
// Self-checking bench for the dual timer/counter pair.
`timescale 1ns/1ps
`include "dtc_params.svh"
module tb_dtc_timer_pair
    import dtc_pkg::*;
;
    logic core_clk, sys_rst, baudTick;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp, countPins, irqPins;
    int mismatches = 0;
    int checks = 0;
    int cyc = 0;
    int t0 = 0;
    dtc_timer_pair u_dtc_timer_pair (.core_clk, .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
        .s_axi_rresp, .countPinZero(countPins[0]), .countPinOne(countPins[1]), .extIrqPinZero(irqPins[0]),
        .extIrqPinOne(irqPins[1]), .baudTick);
    dtc_pin_source u_dtc_pin_source (.clk(core_clk), .countPins(countPins), .irqPins(irqPins));
    // Clock of 25 ns and a free cycle count used to time runs exactly.
    always #12.5 core_clk = ~core_clk;
    always @(posedge core_clk) cyc <= cyc + 1;
    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Write with both halves offered together, each released when taken.
    task automatic axi_write(input logic [7:0] a, input logic [7:0] v);
        int n;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (n = 0; n < 100; n++) begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'h0;
        rsp = s_axi_bresp;
        if (n >= 100) mismatches++;
    endtask
    // Read that holds rready until the data arrive.
    task automatic axi_read(input logic [7:0] a);
        int n;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (n = 0; n < 100; n++) begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'h0;
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        if (n >= 100) mismatches++;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        axi_read(a);
        check(rd, {24'h0, e});
    endtask
    // Runs are timed from one write to another of equal latency, so counts are exact.
    task automatic wait_to(input int n);
        while (cyc < t0 + n) @(posedge core_clk);
    endtask
    task automatic start(input logic [7:0] a, input logic [7:0] v);
        t0 = cyc;
        axi_write(a, v);
    endtask
    task automatic stop_at(input int n, input logic [7:0] a, input logic [7:0] v);
        wait_to(n);
        axi_write(a, v);
    endtask
    // Watchdog far beyond the few thousand cycles the tests need.
    initial begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        final_report();
    end
    // Main sequence of scenarios.
    initial begin
        core_clk = 1'h0;
        sys_rst = 1'h1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'h0;
        for (int a = 0; a < 6; a++) rchk(8'(a * 4), 8'h00);
        axi_write(8'h1C, 8'hFF);
        check(32'(rsp), 32'(`DTC_RESP_SLVERR));
        axi_read(8'h1C);
        check(32'(rsp), 32'(`DTC_RESP_SLVERR));
        rchk(`DTC_ADDR_ACK, 8'h00);
        // Machine-cycle counting in 16-bit mode, then resumed without clearing.
        axi_write(`DTC_ADDR_MODE, 8'h01);
        start(`DTC_ADDR_CTL, 8'h10);
        stop_at(600, `DTC_ADDR_CTL, 8'h00);
        rchk(`DTC_ADDR_TL0, 8'h64);
        start(`DTC_ADDR_CTL, 8'h10);
        stop_at(1200, `DTC_ADDR_CTL, 8'h00);
        rchk(`DTC_ADDR_TL0, 8'h2C);
        rchk(`DTC_ADDR_TH0, 8'h01);
        // 13-bit mode rolls over from all ones.
        axi_write(`DTC_ADDR_TH0, 8'hFF);
        axi_write(`DTC_ADDR_TL0, 8'h1E);
        axi_write(`DTC_ADDR_MODE, 8'h00);
        start(`DTC_ADDR_CTL, 8'h10);
        wait_to(40);
        rchk(`DTC_ADDR_CTL, 8'h30);
        stop_at(60, `DTC_ADDR_CTL, 8'h00);
        axi_read(`DTC_ADDR_TL0);
        check(32'(rd[4:0]), 32'h8);
        rchk(`DTC_ADDR_TH0, 8'h00);
        // Auto-reload mode, flag acknowledged while running.
        axi_write(`DTC_ADDR_TH0, 8'hF0);
        axi_write(`DTC_ADDR_TL0, 8'hFE);
        axi_write(`DTC_ADDR_MODE, 8'h02);
        start(`DTC_ADDR_CTL, 8'h10);
        wait_to(30);
        rchk(`DTC_ADDR_CTL, 8'h30);
        axi_write(`DTC_ADDR_ACK, 8'h20);
        rchk(`DTC_ADDR_CTL, 8'h10);
        stop_at(90, `DTC_ADDR_CTL, 8'h00);
        rchk(`DTC_ADDR_TL0, 8'hFD);
        rchk(`DTC_ADDR_TH0, 8'hF0);
        // Gated counting with a low-level interrupt pin.
        axi_write(`DTC_ADDR_MODE, 8'h09);
        axi_write(`DTC_ADDR_TL0, 8'h00);
        axi_write(`DTC_ADDR_TH0, 8'h00);
        u_dtc_pin_source.setIrq(0, 1'h0);
        start(`DTC_ADDR_CTL, 8'h10);
        wait_to(30);
        rchk(`DTC_ADDR_CTL, 8'h12);
        stop_at(60, `DTC_ADDR_CTL, 8'h00);
        rchk(`DTC_ADDR_TL0, 8'h00);
        u_dtc_pin_source.setIrq(0, 1'h1);
        axi_write(`DTC_ADDR_ACK, 8'h02);
        rchk(`DTC_ADDR_CTL, 8'h00);
        start(`DTC_ADDR_CTL, 8'h10);
        stop_at(60, `DTC_ADDR_CTL, 8'h00);
        rchk(`DTC_ADDR_TL0, 8'h0A);
        // Counter function on falling edges of the count pin.
        axi_write(`DTC_ADDR_MODE, 8'h05);
        axi_write(`DTC_ADDR_TL0, 8'h00);
        axi_write(`DTC_ADDR_CTL, 8'h10);
        u_dtc_pin_source.pulses(0, 5);
        repeat (30) @(posedge core_clk);
        axi_write(`DTC_ADDR_CTL, 8'h00);
        rchk(`DTC_ADDR_TL0, 8'h05);
        // Timer 1 counts, then holds once placed in mode 3.
        axi_write(`DTC_ADDR_MODE, 8'h10);
        start(`DTC_ADDR_CTL, 8'h40);
        stop_at(60, `DTC_ADDR_MODE, 8'h30);
        stop_at(120, `DTC_ADDR_CTL, 8'h00);
        rchk(`DTC_ADDR_TL1, 8'h0A);
        // Timer 0 split into two 8-bit counters.
        axi_write(`DTC_ADDR_MODE, 8'h33);
        axi_write(`DTC_ADDR_TH0, 8'hFF);
        axi_write(`DTC_ADDR_TL0, 8'h00);
        start(`DTC_ADDR_CTL, 8'h50);
        wait_to(40);
        rchk(`DTC_ADDR_CTL, 8'hD0);
        stop_at(60, `DTC_ADDR_CTL, 8'h00);
        rchk(`DTC_ADDR_TL0, 8'h0A);
        rchk(`DTC_ADDR_TH0, 8'h09);
        rchk(`DTC_ADDR_TL1, 8'h0A);
        // Timer 1 switched on and off by leaving and entering mode 3.
        axi_write(`DTC_ADDR_TL1, 8'h00);
        start(`DTC_ADDR_MODE, 8'h03);
        stop_at(60, `DTC_ADDR_MODE, 8'h33);
        rchk(`DTC_ADDR_TL1, 8'h0A);
        rchk(`DTC_ADDR_CTL, 8'h00);
        // Edge-triggered interrupt flag on pin one.
        axi_write(`DTC_ADDR_CTL, 8'h05);
        u_dtc_pin_source.setIrq(1, 1'h0);
        rchk(`DTC_ADDR_CTL, 8'h0D);
        axi_write(`DTC_ADDR_ACK, 8'h08);
        rchk(`DTC_ADDR_CTL, 8'h05);
        u_dtc_pin_source.setIrq(1, 1'h1);
        final_report();
    end
endmodule
